// ==== hsq_axis_model.sv ====
/*
  behavioural axis: limits, home sensor, index pulse and standstill.
  assumes the sequencer's dir, speed and return outputs, clock aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module hsq_axis_model #(
  parameter logic [15:0] FAST = 16'h0040
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dir_fwd_reg,
  input wire logic [15:0] speed_cmd_reg,
  input wire logic return_req_reg,
  output wire logic fwd_lim,
  output wire logic rev_limit_input,
  output wire logic home_sensor_input,
  output wire logic index_pulse_input,
  output wire logic motor_stopped,
  output wire logic in_position
);
  logic [4:0] run_cnt;
  logic [3:0] idx_cnt;
  logic [2:0] stop_cnt;
  logic [2:0] pos_cnt;

  // travel counters; limits and home sensor only fire at fast speed, like a rough home zone
  always @(posedge aclk)
  begin
    if (!aresetn || speed_cmd_reg != FAST) run_cnt <= 5'h00;
    else if (run_cnt != 5'h1f) run_cnt <= run_cnt + 5'h01;
    if (!aresetn || speed_cmd_reg == 16'h0000) idx_cnt <= 4'h0;
    else idx_cnt <= (idx_cnt == 4'hb) ? 4'h0 : idx_cnt + 4'h1;
    if (!aresetn || speed_cmd_reg != 16'h0000) stop_cnt <= 3'h0;
    else if (stop_cnt != 3'h7) stop_cnt <= stop_cnt + 3'h1;
    if (!aresetn || !return_req_reg) pos_cnt <= 3'h0;
    else if (pos_cnt != 3'h7) pos_cnt <= pos_cnt + 3'h1;
  end

  // limit and home levels held four cycles, well over the two-cycle minimum; index pulse held two
  assign fwd_lim = run_cnt >= 5'h0a && run_cnt < 5'h0e && dir_fwd_reg;
  assign rev_limit_input = run_cnt >= 5'h0a && run_cnt < 5'h0e && !dir_fwd_reg;
  assign home_sensor_input = run_cnt >= 5'h0a && run_cnt < 5'h0e;
  assign index_pulse_input = speed_cmd_reg != 16'h0000 && idx_cnt >= 4'ha;
  assign motor_stopped = stop_cnt >= 3'h3;
  assign in_position = pos_cnt >= 3'h4;
endmodule // hsq_axis_model
`default_nettype wire

// ==== hsq_consts.vh ====
/*
  shared constants of the homing sequencer: register indices, mode word
  field positions, reset values and the fixed offset scale.
  assumes inclusion by bare name from the design files.
*/
`ifndef HSQ_CONSTS_VH
`define HSQ_CONSTS_VH
// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define HSQ_IDX_ACCEL 10'h122
`define HSQ_IDX_DECEL 10'h123
`define HSQ_IDX_CURVE 10'h124
`define HSQ_IDX_MODE 10'h12f
`define HSQ_IDX_FAST 10'h130
`define HSQ_IDX_SLOW 10'h131
`define HSQ_IDX_TURNS 10'h132
`define HSQ_IDX_PULSES 10'h133
`define HSQ_IDX_CTRL 10'h140
`define HSQ_IDX_STATUS 10'h141
`define HSQ_IDX_OFFSET 10'h142
// ----------------------------------------------------------------------
// config storage slots
// ----------------------------------------------------------------------
`define HSQ_SLOT_ACCEL 3'h0
`define HSQ_SLOT_DECEL 3'h1
`define HSQ_SLOT_CURVE 3'h2
`define HSQ_SLOT_MODE 3'h3
`define HSQ_SLOT_FAST 3'h4
`define HSQ_SLOT_SLOW 3'h5
`define HSQ_SLOT_TURNS 3'h6
`define HSQ_SLOT_PULSES 3'h7
// ----------------------------------------------------------------------
// mode word digits, control bits, reset values and response codes
// ----------------------------------------------------------------------
`define HSQ_MODE_SRC_LSB 0
`define HSQ_MODE_IDX_LSB 4
`define HSQ_MODE_EN_LSB 8
`define HSQ_MODE_STOP_LSB 12
`define HSQ_CTRL_TRIG_NC 0
`define HSQ_CTRL_CLR_LIM 1
`define HSQ_CTRL_CLR_ABT 2
`define HSQ_RST_CFG 16'h0000
`define HSQ_RST_CTRL 1'b0
`define HSQ_PULSES_PER_TURN 16'h2710
`define HSQ_RESP_OKAY 2'h0
`define HSQ_RESP_SLVERR 2'h2
`endif

// ==== hsq_homing.v ====
/*
  homing sequencer for a servo axis with an axi4-lite register slave.
  assumes a motion stage outside that follows dir/speed/stop commands
  and reports standstill and in-position; all inputs share aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hsq_consts.vh"
module hsq_homing (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire fwd_limit_input,
  input wire rev_limit_input,
  input wire home_sensor_input,
  input wire index_pulse_input,
  input wire homing_trigger_input,
  input wire servo_on,
  input wire alarm_in,
  input wire motor_stopped,
  input wire in_position,
  output reg homing_busy_reg,
  output reg home_done_reg,
  output reg limit_alarm_reg,
  output reg dir_fwd_reg,
  output reg [15:0] speed_cmd_reg,
  output reg decel_stop_reg,
  output reg return_req_reg,
  output reg home_latch_reg,
  output reg ramp_en_reg,
  output reg [15:0] accel_cmd_reg,
  output reg [15:0] decel_cmd_reg,
  output reg [31:0] home_offset_reg
);
  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 3'd0;
  localparam ST_FAST = 3'd1;
  localparam ST_SLOW = 3'd2;
  localparam ST_STOP = 3'd3;
  localparam ST_BACK = 3'd4;

  reg [2:0] state_reg;
  reg [15:0] cfg_mem [0:7];
  reg trig_nc_reg;
  reg auto_done_reg;
  reg home_est_reg;
  reg aborted_reg;
  reg [9:0] aw_idx_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  wire [4:0] in_lvl;
  wire [4:0] in_rise;
  wire [4:0] in_fall;
  hsq_sync_edge #(
    .N(5)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({homing_trigger_input, index_pulse_input, home_sensor_input,
          rev_limit_input, fwd_limit_input}),
    .lvl(in_lvl),
    .rise(in_rise),
    .fall(in_fall)
  );

  // mode word fields
  wire [15:0] mode_w = cfg_mem[`HSQ_SLOT_MODE];
  wire [3:0] src_a = mode_w[`HSQ_MODE_SRC_LSB +: 4];
  wire [3:0] meth_b = mode_w[`HSQ_MODE_IDX_LSB +: 4];
  wire [3:0] en_c = mode_w[`HSQ_MODE_EN_LSB +: 4];
  wire [3:0] stop_d = mode_w[`HSQ_MODE_STOP_LSB +: 4];

  // ----------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------
  reg rough_ev;
  always @*
  begin
    case (src_a)
      4'h0: rough_ev = in_rise[0];
      4'h1: rough_ev = in_rise[1];
      4'h2: rough_ev = in_rise[2];
      4'h3: rough_ev = in_rise[2];
      4'h4: rough_ev = in_rise[3];
      4'h5: rough_ev = in_rise[3];
      default: rough_ev = 1'b0;
    endcase
  end

  // a contact "b" trigger is active on its opening edge
  wire trig_act = trig_nc_reg ? in_fall[4] : in_rise[4];
  wire start_auto = (en_c == 4'h1) && servo_on && !auto_done_reg;
  wire start_trig = (en_c == 4'h2) && servo_on && trig_act;
  wire start_req = (start_auto || start_trig) && !alarm_in;
  wire abort_req = (state_reg != ST_IDLE) && (!servo_on || alarm_in);
  // the limit input selected as source returns to limit duty once home is established
  wire lim_hit = home_est_reg &&
    (((src_a == 4'h0) && in_rise[0]) || ((src_a == 4'h1) && in_rise[1]));
  // index source or method 2 ends at the first detected edge
  wire direct_home = (src_a == 4'h4) || (src_a == 4'h5) || (meth_b == 4'h2);

  // ----------------------------------------------------------------------
  // axi write path
  // ----------------------------------------------------------------------
  wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ctrl = wr_fire && (aw_idx_reg == `HSQ_IDX_CTRL) && wstrb_reg[0];
  wire clr_lim = wr_ctrl && wdata_reg[`HSQ_CTRL_CLR_LIM];
  wire clr_abt = wr_ctrl && wdata_reg[`HSQ_CTRL_CLR_ABT];

  // map an index to a config slot; bit 3 flags a hit
  function [3:0] slot_of;
    input [9:0] idx;
    begin
      case (idx)
        `HSQ_IDX_ACCEL: slot_of = {1'b1, `HSQ_SLOT_ACCEL};
        `HSQ_IDX_DECEL: slot_of = {1'b1, `HSQ_SLOT_DECEL};
        `HSQ_IDX_CURVE: slot_of = {1'b1, `HSQ_SLOT_CURVE};
        `HSQ_IDX_MODE: slot_of = {1'b1, `HSQ_SLOT_MODE};
        `HSQ_IDX_FAST: slot_of = {1'b1, `HSQ_SLOT_FAST};
        `HSQ_IDX_SLOW: slot_of = {1'b1, `HSQ_SLOT_SLOW};
        `HSQ_IDX_TURNS: slot_of = {1'b1, `HSQ_SLOT_TURNS};
        `HSQ_IDX_PULSES: slot_of = {1'b1, `HSQ_SLOT_PULSES};
        default: slot_of = 4'h0;
      endcase
    end
  endfunction

  wire [3:0] wslot = slot_of(aw_idx_reg);
  wire wr_ok = wslot[3] || (aw_idx_reg == `HSQ_IDX_CTRL);

  // address and data are taken independently, answered once both held
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HSQ_RESP_OKAY;
      aw_idx_reg <= 10'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      trig_nc_reg <= `HSQ_RST_CTRL;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_idx_reg <= s_axi_awaddr[11:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `HSQ_RESP_OKAY : `HSQ_RESP_SLVERR;
        if (wr_ctrl)
          trig_nc_reg <= wdata_reg[`HSQ_CTRL_TRIG_NC];
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // config storage, two low byte lanes carry the 16-bit value
  always @(posedge aclk)
  begin : p_cfg
    integer k;
    if (!aresetn)
    begin
      for (k = 0; k < 8; k = k + 1)
        cfg_mem[k] <= `HSQ_RST_CFG;
    end
    else if (wr_fire && wslot[3])
    begin
      if (wstrb_reg[0])
        cfg_mem[wslot[2:0]][7:0] <= wdata_reg[7:0];
      if (wstrb_reg[1])
        cfg_mem[wslot[2:0]][15:8] <= wdata_reg[15:8];
    end
  end

  // ----------------------------------------------------------------------
  // axi read path
  // ----------------------------------------------------------------------
  wire [3:0] rslot = slot_of(s_axi_araddr[11:2]);
  reg [31:0] rd_val;
  reg rd_ok;
  always @*
  begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    if (rslot[3])
      rd_val = {16'h0000, cfg_mem[rslot[2:0]]};
    else if (s_axi_araddr[11:2] == `HSQ_IDX_CTRL)
      rd_val = {31'h0000_0000, trig_nc_reg};
    else if (s_axi_araddr[11:2] == `HSQ_IDX_STATUS)
      rd_val = {24'h000000, state_reg, limit_alarm_reg, aborted_reg,
                home_est_reg, home_done_reg, homing_busy_reg};
    else if (s_axi_araddr[11:2] == `HSQ_IDX_OFFSET)
      rd_val = home_offset_reg;
    else
      rd_ok = 1'b0;
  end

  // one-cycle read answer, next address accepted after rready
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HSQ_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `HSQ_RESP_OKAY : `HSQ_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // derived motion settings
  // ----------------------------------------------------------------------
  wire [31:0] offset_next = cfg_mem[`HSQ_SLOT_TURNS] * `HSQ_PULSES_PER_TURN
    + {16'h0000, cfg_mem[`HSQ_SLOT_PULSES]};
  wire ramp_next = (cfg_mem[`HSQ_SLOT_CURVE] != 16'h0000);

  // registered so the motion stage sees clean levels
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      home_offset_reg <= 32'h0000_0000;
      ramp_en_reg <= 1'b0;
      accel_cmd_reg <= 16'h0000;
      decel_cmd_reg <= 16'h0000;
    end
    else
    begin
      home_offset_reg <= offset_next;
      ramp_en_reg <= ramp_next;
      accel_cmd_reg <= ramp_next ? cfg_mem[`HSQ_SLOT_ACCEL] : 16'h0000;
      decel_cmd_reg <= ramp_next ? cfg_mem[`HSQ_SLOT_DECEL] : 16'h0000;
    end
  end

  // ----------------------------------------------------------------------
  // sticky flags, a new event wins over a software clear
  // ----------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      limit_alarm_reg <= 1'b0;
      aborted_reg <= 1'b0;
    end
    else
    begin
      if (lim_hit)
        limit_alarm_reg <= 1'b1;
      else if (clr_lim)
        limit_alarm_reg <= 1'b0;
      if (abort_req)
        aborted_reg <= 1'b1;
      else if (clr_abt)
        aborted_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // homing sequence
  // ----------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= ST_IDLE;
      homing_busy_reg <= 1'b0;
      home_done_reg <= 1'b0;
      home_est_reg <= 1'b0;
      auto_done_reg <= 1'b0;
      dir_fwd_reg <= 1'b1;
      speed_cmd_reg <= 16'h0000;
      decel_stop_reg <= 1'b0;
      return_req_reg <= 1'b0;
      home_latch_reg <= 1'b0;
    end
    else if (abort_req)
    begin
      // no completion is reported for an interrupted run
      state_reg <= ST_IDLE;
      homing_busy_reg <= 1'b0;
      speed_cmd_reg <= 16'h0000;
      decel_stop_reg <= 1'b0;
      return_req_reg <= 1'b0;
      home_latch_reg <= 1'b0;
    end
    else
    begin
      home_latch_reg <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_req)
          begin
            state_reg <= ST_FAST;
            homing_busy_reg <= 1'b1;
            home_done_reg <= 1'b0;
            home_est_reg <= 1'b0;
            auto_done_reg <= 1'b1;
            dir_fwd_reg <= ~src_a[0];
            speed_cmd_reg <= cfg_mem[`HSQ_SLOT_FAST];
          end
        end
        ST_FAST:
        begin
          if (rough_ev && direct_home)
          begin
            state_reg <= ST_STOP;
            home_latch_reg <= 1'b1;
            speed_cmd_reg <= 16'h0000;
            decel_stop_reg <= 1'b1;
          end
          else if (rough_ev)
          begin
            state_reg <= ST_SLOW;
            speed_cmd_reg <= cfg_mem[`HSQ_SLOT_SLOW];
            if (meth_b == 4'h0)
              dir_fwd_reg <= ~dir_fwd_reg;
          end
        end
        ST_SLOW:
        begin
          // method 1 keeps the direction set by the search
          if (in_rise[3])
          begin
            state_reg <= ST_STOP;
            home_latch_reg <= 1'b1;
            speed_cmd_reg <= 16'h0000;
            decel_stop_reg <= 1'b1;
          end
        end
        ST_STOP:
        begin
          if (motor_stopped)
          begin
            decel_stop_reg <= 1'b0;
            if (stop_d == 4'h0)
            begin
              state_reg <= ST_BACK;
              return_req_reg <= 1'b1;
            end
            else
            begin
              state_reg <= ST_IDLE;
              homing_busy_reg <= 1'b0;
              home_done_reg <= 1'b1;
              home_est_reg <= 1'b1;
            end
          end
        end
        ST_BACK:
        begin
          if (in_position)
          begin
            state_reg <= ST_IDLE;
            return_req_reg <= 1'b0;
            homing_busy_reg <= 1'b0;
            home_done_reg <= 1'b1;
            home_est_reg <= 1'b1;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          homing_busy_reg <= 1'b0;
        end
      endcase
    end
  end
endmodule // hsq_homing
`default_nettype wire

// ==== hsq_homing_chk.sv ====
/*
  port checker of the homing sequencer: abort, stop and completion relations.
  assumes binding onto hsq_homing, one clock aclk, sync active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hsq_homing_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic servo_on,
  input wire logic alarm_in,
  input wire logic in_position,
  input wire logic homing_busy_reg,
  input wire logic home_done_reg,
  input wire logic [15:0] speed_cmd_reg,
  input wire logic decel_stop_reg,
  input wire logic return_req_reg,
  input wire logic home_latch_reg,
  input wire logic ramp_en_reg,
  input wire logic [15:0] accel_cmd_reg,
  input wire logic [15:0] decel_cmd_reg
);
  // ----------------------------------------
  // single domain, reset masks every check
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_done_not_busy: assert property (home_done_reg |-> !homing_busy_reg)
    else $error("done flag set while busy");
  a_servo_abort: assert property (homing_busy_reg && !servo_on
    |=> !homing_busy_reg && !home_done_reg) else $error("servo-off did not abort");
  a_alarm_abort: assert property (homing_busy_reg && alarm_in
    |=> !homing_busy_reg && speed_cmd_reg == 16'h0000 && !decel_stop_reg && !return_req_reg)
    else $error("alarm did not stop motion");
  a_latch_stops: assert property (home_latch_reg
    |-> speed_cmd_reg == 16'h0000 && decel_stop_reg) else $error("home latch without stop");
  a_latch_single: assert property (home_latch_reg |=> !home_latch_reg)
    else $error("home latch longer than one cycle");
  a_decel_zero: assert property (decel_stop_reg |-> speed_cmd_reg == 16'h0000)
    else $error("speed during deceleration");
  a_ramp_off: assert property (!ramp_en_reg
    |-> accel_cmd_reg == 16'h0000 && decel_cmd_reg == 16'h0000) else $error("ramp times leak");
  a_done_cause: assert property ($rose(home_done_reg)
    |-> $past(decel_stop_reg) || $past(return_req_reg)) else $error("done without stop");
  a_return_wait: assert property (return_req_reg && !in_position |=> !home_done_reg)
    else $error("done before return finished");
  a_start_gate: assert property ($rose(homing_busy_reg)
    |-> $past(servo_on) && !$past(alarm_in)) else $error("start without servo");
endmodule // hsq_homing_chk

bind hsq_homing hsq_homing_chk u_chk (
  .aclk, .aresetn, .servo_on, .alarm_in, .in_position, .homing_busy_reg, .home_done_reg,
  .speed_cmd_reg, .decel_stop_reg, .return_req_reg, .home_latch_reg, .ramp_en_reg,
  .accel_cmd_reg, .decel_cmd_reg
);
`default_nettype wire

// ==== hsq_sync_edge.v ====
/*
  per-bit two-flop synchroniser with rise and fall detection.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hsq_sync_edge #(
  parameter N = 5
) (
  input wire aclk,
  input wire aresetn,
  input wire [N-1:0] din,
  output wire [N-1:0] lvl,
  output wire [N-1:0] rise,
  output wire [N-1:0] fall
);
  // ----------------------------------------------------------------------
  // synchroniser chain per bit
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      // s1 only feeds s2, edges use the settled stages
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= din[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      assign lvl[i] = s2_reg;
      assign rise[i] = s2_reg & ~s3_reg;
      assign fall[i] = ~s2_reg & s3_reg;
    end
  endgenerate
endmodule // hsq_sync_edge
`default_nettype wire

// ==== hsq_tb.sv ====
/*
  self-checking bench of the homing sequencer over axi4-lite and pins.
  assumes hsq_homing, hsq_axis_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hsq_consts.vh"
module tb;
  localparam logic [15:0] FAST = 16'h0040;
  localparam logic [15:0] SLOW = 16'h0010;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic homing_trigger_input = 1'h0, servo_on = 1'h0, alarm_in = 1'h0, poke_fwd = 1'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, home_offset_reg;
  wire fwd_limit_input, m_fwd, rev_limit_input, home_sensor_input, index_pulse_input;
  wire motor_stopped, in_position, homing_busy_reg, home_done_reg, limit_alarm_reg;
  wire dir_fwd_reg, decel_stop_reg, return_req_reg, home_latch_reg, ramp_en_reg;
  wire [15:0] speed_cmd_reg, accel_cmd_reg, decel_cmd_reg;
  int n_checks = 0;
  int n_mismatch = 0;

  // ----------------------------------------
  // clock, wiring, instances
  // ----------------------------------------
  always #25 aclk = ~aclk;
  assign fwd_limit_input = m_fwd | poke_fwd;
  hsq_homing dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fwd_limit_input, .rev_limit_input,
    .home_sensor_input, .index_pulse_input, .homing_trigger_input, .servo_on, .alarm_in,
    .motor_stopped, .in_position, .homing_busy_reg, .home_done_reg, .limit_alarm_reg,
    .dir_fwd_reg, .speed_cmd_reg, .decel_stop_reg, .return_req_reg, .home_latch_reg,
    .ramp_en_reg, .accel_cmd_reg, .decel_cmd_reg, .home_offset_reg);
  hsq_axis_model #(.FAST(FAST)) u_axis (.aclk, .aresetn, .dir_fwd_reg, .speed_cmd_reg,
    .return_req_reg, .fwd_lim(m_fwd), .rev_limit_input, .home_sensor_input,
    .index_pulse_input, .motor_stopped, .in_position);

  // ----------------------------------------
  // reporting and bus tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tmo(input string msg);
    n_mismatch++;
    $display("wrong value at %0t: %s timed out", $time, msg);
    give_verdict();
  endtask

  // both channels offered together; an extra edge keeps strobes from double drive
  task automatic axi_wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
    int i;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'h0;
    if (i == 50) tmo("write");
    chk(32'(s_axi_bresp), 32'(er), "bresp");
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    int i;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'h0;
    if (i == 50) tmo("read");
    chk(s_axi_rdata, d, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // homing helpers
  // ----------------------------------------
  task automatic trig;
    homing_trigger_input <= 1'h1;
    repeat (4) @(posedge aclk);
    homing_trigger_input <= 1'h0;
  endtask

  task automatic wait_busy;
    int i;
    for (i = 0; i < 30 && homing_busy_reg !== 1'h1; i++) @(posedge aclk);
    if (i == 30) tmo("start");
  endtask

  task automatic wait_done(output logic ret);
    int i;
    ret = 1'h0;
    for (i = 0; i < 300 && home_done_reg !== 1'h1; i++)
    begin
      if (return_req_reg === 1'h1) ret = 1'h1;
      @(posedge aclk);
    end
    if (i == 300) tmo("done");
    chk(32'(homing_busy_reg), 32'h0, "busy at end");
  endtask

  task automatic run_home(input logic [15:0] m);
    logic r;
    int i;
    axi_wr(`HSQ_IDX_MODE, m, 2'h0);
    trig();
    wait_busy();
    chk(32'(dir_fwd_reg), 32'(!m[0]), "start dir");
    chk(32'(speed_cmd_reg), 32'(FAST), "fast");
    for (i = 0; i < 60 && speed_cmd_reg === FAST; i++) @(posedge aclk);
    if (i == 60) tmo("rough home");
    if (m[3:0] >= 4'h4 || m[7:4] == 4'h2)
      chk(32'(decel_stop_reg), 32'h1, "direct stop");
    else
    begin
      chk(32'(speed_cmd_reg), 32'(SLOW), "slow");
      chk(32'(dir_fwd_reg), 32'(m[0] ^ m[4]), "slow dir");
    end
    wait_done(r);
    chk(32'(r), 32'(m[15:12] == 4'h0), "return move");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_auto;
    logic r;
    axi_wr(`HSQ_IDX_FAST, FAST, 2'h0);
    axi_wr(`HSQ_IDX_SLOW, SLOW, 2'h0);
    axi_wr(`HSQ_IDX_MODE, 16'h1102, 2'h0);
    repeat (10) @(posedge aclk);
    chk(32'(homing_busy_reg), 32'h0, "auto without servo");
    servo_on <= 1'h1;
    wait_busy();
    wait_done(r);
    chk(32'(home_done_reg), 32'h1, "auto done");
    repeat (20) @(posedge aclk);
    chk(32'(homing_busy_reg), 32'h0, "auto rerun");
    $display("test auto start done");
  endtask

  task automatic t_regs;
    axi_wr(`HSQ_IDX_TURNS, 16'h0002, 2'h0);
    axi_wr(`HSQ_IDX_PULSES, 16'h0005, 2'h0);
    chk(home_offset_reg, 32'h00004e25, "offset port");
    axi_rd(`HSQ_IDX_OFFSET, 32'h00004e25, 2'h0);
    axi_rd(`HSQ_IDX_MODE, 32'h00001102, 2'h0);
    axi_rd(`HSQ_IDX_FAST, {16'h0000, FAST}, 2'h0);
    axi_wr(`HSQ_IDX_ACCEL, 16'h0123, 2'h0);
    axi_wr(`HSQ_IDX_CURVE, 16'h0001, 2'h0);
    chk(32'(accel_cmd_reg), 32'h123, "accel on");
    axi_wr(`HSQ_IDX_CURVE, 16'h0000, 2'h0);
    chk(32'(ramp_en_reg), 32'h0, "ramp off");
    chk(32'(accel_cmd_reg), 32'h0, "accel off");
    axi_wr(10'h100, 16'h0055, 2'h2);
    axi_rd(10'h100, 32'h0, 2'h2);
    $display("test registers done");
  endtask

  task automatic t_modes;
    // source and method pairs stay within the allowed combinations
    logic [15:0] tbl [6] = '{16'h1200, 16'h0201, 16'h1212, 16'h0223, 16'h1224, 16'h1225};
    foreach (tbl[k]) run_home(tbl[k]);
    $display("test homing modes done");
  endtask

  task automatic t_limit;
    run_home(16'h1200);
    poke_fwd <= 1'h1;
    repeat (5) @(posedge aclk);
    poke_fwd <= 1'h0;
    chk(32'(limit_alarm_reg), 32'h1, "limit alarm");
    axi_wr(`HSQ_IDX_CTRL, 16'h0002, 2'h0);
    chk(32'(limit_alarm_reg), 32'h0, "alarm cleared");
    $display("test limit duty done");
  endtask

  task automatic t_disabled;
    axi_wr(`HSQ_IDX_MODE, 16'h1002, 2'h0);
    trig();
    repeat (10) @(posedge aclk);
    chk(32'(homing_busy_reg), 32'h0, "disabled start");
    $display("test disabled done");
  endtask

  task automatic t_abort;
    axi_wr(`HSQ_IDX_MODE, 16'h1202, 2'h0);
    trig();
    wait_busy();
    servo_on <= 1'h0;
    repeat (3) @(posedge aclk);
    chk(32'({homing_busy_reg, home_done_reg}), 32'h0, "servo abort");
    servo_on <= 1'h1;
    axi_wr(`HSQ_IDX_CTRL, 16'h0001, 2'h0);
    trig();
    wait_busy();
    alarm_in <= 1'h1;
    repeat (3) @(posedge aclk);
    chk(32'({homing_busy_reg, home_done_reg}), 32'h0, "alarm abort");
    alarm_in <= 1'h0;
    axi_rd(`HSQ_IDX_STATUS, 32'h00000008, 2'h0);
    $display("test abort done");
  endtask

  // main sequence: reset held twenty cycles, then every scenario
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_auto();
    t_regs();
    t_modes();
    t_limit();
    t_disabled();
    t_abort();
    give_verdict();
  end
endmodule // tb
`default_nettype wire
